// ===== shared/nmb_pkg.sv
// package for the normal-memory byte lane select block
// assumes a single 20 MHz system clock and synchronous active-high reset
package nmb_pkg;
  // ==========================================================
  // strap decodes
  localparam logic [1:0] WIDTH_8 = 2'h1;
  localparam logic [1:0] WIDTH_16 = 2'h2;
  localparam logic [1:0] WIDTH_32 = 2'h3;
  // ==========================================================
  // access sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  // ==========================================================
  // reset values and widths
  localparam int ADDR_W = 26;
  localparam int AREA_N = 7;
  localparam logic [3:0] LANES_IDLE = 4'h f;
  localparam logic [2:0] CLK_MODE_RST = 3'h0;
  // one-cycle minimum strobe phase
  localparam int STROBE_NS = 50;
  localparam int CLK_NS = 50;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================
  // bus cycle states
  typedef enum logic [3:0] {
    NMB_IDLE = 4'b0001,
    NMB_START = 4'b0010,
    NMB_STROBE = 4'b0100,
    NMB_END = 4'b1000
  } nmb_state_t;
endpackage

// ===== rtl/nmb_strap.sv
// strap capture for clock mode, area 0 width and endian
// assumes straps stable while reset is high
`timescale 1ns/10ps
module nmb_strap (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_mode_strap_0,
  input wire logic clock_mode_strap_1,
  input wire logic clock_mode_strap_2,
  input wire logic area0_width_strap_0,
  input wire logic area0_width_strap_1,
  input wire logic endian_strap,
  output logic [2:0] clock_mode,
  output logic [1:0] area0_width,
  output logic big_endian
);
  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] width;
    logic big;
  } nmb_strap_t;
  nmb_strap_t s_q, s_d;
  // ==========================================================
  // straps sampled only while reset is held, then frozen
  always_comb begin
    s_d = s_q;
    if (rst) begin
      s_d.mode = {clock_mode_strap_2, clock_mode_strap_1, clock_mode_strap_0};
      s_d.width = {area0_width_strap_1, area0_width_strap_0};
      s_d.big = endian_strap;
    end
  end
  always_ff @(posedge clock) begin
    s_q <= s_d;
  end
  assign clock_mode = s_q.mode;
  assign area0_width = s_q.width;
  assign big_endian = s_q.big;
endmodule // nmb_strap

// ===== rtl/nmb_lanes.sv
// lane decode: write selects and data lane enables for one bus cycle
// assumes little-endian 8/16-bit decode; 32-bit decoded like 16-bit, upper two lanes stay off
`timescale 1ns/10ps
module nmb_lanes (
  input wire logic [1:0] width,
  input wire logic [1:0] size,
  input wire logic addr0,
  input wire logic write,
  output logic [3:0] we_n,
  output logic [3:0] lane_oe
);
  logic wide;
  logic lane0;
  logic lane1;
  // ==========================================================
  // 8-bit bus uses lane 0 only; 16-bit picks by size and address bit 0
  always_comb begin
    wide = (size != nmb_pkg::SIZE_BYTE);
    lane0 = (width == nmb_pkg::WIDTH_8) || wide || !addr0;
    lane1 = (width != nmb_pkg::WIDTH_8) && (wide || addr0);
    we_n = nmb_pkg::LANES_IDLE;
    if (write) begin
      we_n[0] = !lane0;
      we_n[1] = !lane1;
    end
    lane_oe = {2'h0, lane1, lane0};
  end
endmodule // nmb_lanes

// ===== rtl/nmb_bus.sv
// normal-memory external bus controller, 8/16-bit little endian
// assumes one requester with req/ack handshake, wait input synchronous
//
// Contract
// - clock mode straps are latched during reset only
// - endian straps selects byte order; here it is only latched onto big_endian, lanes stay little endian
// - every access asserts bus start and, except in area 1, the addressed area select
// - read strobe low on reads, high on writes
// - direction output high for reads, low for writes
// - all write selects high during reads
// - lane 0 write select low per width, size and address
// - lane 1 write select low for 16-bit odd byte or wider
// - upper two write selects stay high on 8/16-bit widths
// - lane 0 carries data except odd byte on 16-bit bus
// - lane 1 off on 8-bit, valid for odd byte or wider
// - upper sixteen data lines never driven
// - sdram row and column strobes stay high
// - card enables high, clock enable off, card 16-bit input ignored
// - wait input stretches the strobe phase
// - full 26-bit byte address driven every access
`timescale 1ns/10ps
module nmb_bus #(
  parameter int AREA_W = 3
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_mode_strap_0,
  input wire logic clock_mode_strap_1,
  input wire logic clock_mode_strap_2,
  input wire logic area0_width_strap_0,
  input wire logic area0_width_strap_1,
  input wire logic endian_strap,
  input wire logic req,
  input wire logic req_write,
  input wire logic [1:0] req_size,
  input wire logic [2:0] req_area,
  input wire logic [1:0] req_width,
  input wire logic [25:0] req_addr,
  input wire logic [31:0] req_wdata,
  output logic ack,
  output logic [31:0] rdata,
  output logic [2:0] clock_mode,
  output logic big_endian,
  output logic [25:0] addr,
  output logic area0_select_n,
  output logic [4:0] area_selects_n,
  output logic bus_cycle_start_n,
  output logic read_n,
  output logic read_write,
  output logic lane0_write_select_n,
  output logic lane1_write_select_n,
  output logic lane2_write_select_n,
  output logic lane3_write_select_n,
  output logic upper_row_strobe_n,
  output logic lower_row_strobe_n,
  output logic upper_column_strobe_n,
  output logic lower_column_strobe_n,
  output logic card_a_second_enable_n,
  output logic card_b_second_enable_n,
  output logic sdram_clock_enable,
  input wire logic card_io_16bit_indicator,
  input wire logic wait_n,
  input wire logic [31:0] data_in,
  output logic [31:0] data_out,
  output logic [31:0] data_oe
);
  // ==========================================================
  // elaboration checks: the pin logic below is written for these values
  // area code width: seven areas fit three bits
  if (AREA_W != 3) begin : g_bad_area
    $error("area field must be 3 bits");
  end
  // address pins carry one fixed 26-bit byte address
  if (nmb_pkg::ADDR_W != 26) begin : g_bad_addr
    $error("address bus must be 26 bits");
  end
  // areas 0 and 2..6 have selects, area 1 has none
  if (nmb_pkg::AREA_N != 7) begin : g_bad_area_n
    $error("seven areas expected");
  end
  // idle write selects are all high
  if (nmb_pkg::LANES_IDLE != 4'hf) begin : g_bad_idle
    $error("idle write selects must be high");
  end
  // the sequencer holds one strobe cycle before it looks at wait
  if (nmb_pkg::STROBE_CYC != 1) begin : g_bad_strobe
    $error("strobe phase must be one cycle");
  end
  // width and size codes must decode apart
  if (nmb_pkg::WIDTH_8 == nmb_pkg::WIDTH_16) begin : g_bad_width
    $error("bus width codes collide");
  end
  if (nmb_pkg::SIZE_BYTE == nmb_pkg::SIZE_WORD || nmb_pkg::SIZE_WORD == nmb_pkg::SIZE_LONG) begin : g_bad_size
    $error("access size codes collide");
  end

  // ==========================================================
  // sequencer state
  // the whole request is latched when taken, so the requester may move on;
  // beat and beats step the byte cycles of an 8-bit bus
  typedef struct packed {
    nmb_pkg::nmb_state_t st;
    logic write;
    logic [1:0] size;
    logic [1:0] width;
    logic [2:0] area;
    logic [25:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [1:0] beat;
    logic [1:0] beats;
    logic ack;
  } nmb_bus_t;
  nmb_bus_t r_q, r_d;

  // strap width, lane decode and the width and size of the byte cycle in flight
  logic [1:0] area0_width;
  logic [3:0] we_n;
  logic [3:0] lane_oe;
  logic [1:0] cyc_size;
  logic [1:0] eff_width;
  logic active;
  logic strobe;

  // ==========================================================
  // strap capture
  nmb_strap u_strap (
    .clock(clock),
    .rst(rst),
    .clock_mode_strap_0(clock_mode_strap_0),
    .clock_mode_strap_1(clock_mode_strap_1),
    .clock_mode_strap_2(clock_mode_strap_2),
    .area0_width_strap_0(area0_width_strap_0),
    .area0_width_strap_1(area0_width_strap_1),
    .endian_strap(endian_strap),
    .clock_mode(clock_mode),
    .area0_width(area0_width),
    .big_endian(big_endian)
  );

  // ==========================================================
  // width of a request: area 0 from straps, others from requester
  function automatic logic [1:0] pick_width(input logic [2:0] area, input logic [1:0] strap_w,
                                            input logic [1:0] rq_w);
    pick_width = (area == 3'h0) ? strap_w : rq_w;
  endfunction

  // number of byte beats minus one on an 8-bit bus
  function automatic logic [1:0] beats_of(input logic [1:0] w, input logic [1:0] sz);
    if (w != nmb_pkg::WIDTH_8) begin
      beats_of = 2'h0;
    end else if (sz == nmb_pkg::SIZE_LONG) begin
      beats_of = 2'h3;
    end else if (sz == nmb_pkg::SIZE_WORD) begin
      beats_of = 2'h1;
    end else begin
      beats_of = 2'h0;
    end
  endfunction

  // area decode shared by every chip select
  function automatic logic area_hit(input logic busy, input logic [2:0] cur, input logic [2:0] want);
    area_hit = busy && (cur == want);
  endfunction

  assign eff_width = r_q.width;
  assign cyc_size = (eff_width == nmb_pkg::WIDTH_8) ? nmb_pkg::SIZE_BYTE : r_q.size;

  // ==========================================================
  // lane decode for the current cycle
  nmb_lanes u_lanes (
    .width(eff_width),
    .size(cyc_size),
    .addr0(r_q.addr[0]),
    .write(r_q.write),
    .we_n(we_n),
    .lane_oe(lane_oe)
  );

  // ==========================================================
  // bus cycle sequencer
  // idle: request latched, width resolved, beat count set
  // start: bus start pulse, select and address out
  // strobe: read strobe or write selects low, held while wait is low
  // end: strobes released, address and data held one more cycle
  // an 8-bit bus runs start..end once per byte with the address stepped
  // the acknowledge pulse follows the last end state
  // a request seen while busy is ignored; the requester waits for ack
  always_comb begin
    r_d = r_q;
    r_d.ack = 1'b0;
    case (r_q.st)
      nmb_pkg::NMB_IDLE: begin
        // latch the request; read data restarts from zero
        if (req) begin
          r_d.write = req_write;
          r_d.size = req_size;
          r_d.area = req_area;
          r_d.width = pick_width(req_area, area0_width, req_width);
          r_d.addr = req_addr;
          r_d.wdata = req_wdata;
          r_d.rdata = 32'h0000_0000;
          r_d.beat = 2'h0;
          r_d.beats = beats_of(r_d.width, req_size);
          r_d.st = nmb_pkg::NMB_START;
        end
      end
      nmb_pkg::NMB_START: begin
        // address setup cycle with the start pulse
        r_d.st = nmb_pkg::NMB_STROBE;
      end
      nmb_pkg::NMB_STROBE: begin
        // read data taken on the edge that leaves the strobe phase
        if (wait_n) begin
          r_d.st = nmb_pkg::NMB_END;
          if (!r_q.write) begin
            if (eff_width == nmb_pkg::WIDTH_8) begin
              r_d.rdata[8*r_q.beat +: 8] = data_in[7:0];
            end else begin
              r_d.rdata = {16'h0000, data_in[15:0]};
            end
          end
        end
      end
      nmb_pkg::NMB_END: begin
        // hold cycle, then the next byte or the acknowledge
        if (r_q.beat != r_q.beats) begin
          r_d.beat = r_q.beat + 2'h1;
          r_d.addr = r_q.addr + 26'h000_0001;
          r_d.st = nmb_pkg::NMB_START;
        end else begin
          r_d.ack = 1'b1;
          r_d.st = nmb_pkg::NMB_IDLE;
        end
      end
      default: r_d.st = nmb_pkg::NMB_IDLE;
    endcase
  end

  // reset parks the sequencer idle with every pin inactive
  always_ff @(posedge clock) begin
    if (rst) begin
      r_q <= '0;
      r_q.st <= nmb_pkg::NMB_IDLE;
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // pin drive
  // selects span start..end so the far side sees one unbroken enable;
  // strobes only in the strobe state leave a setup and a hold cycle
  // around them for address and data
  assign active = (r_q.st != nmb_pkg::NMB_IDLE);
  assign strobe = (r_q.st == nmb_pkg::NMB_STROBE);
  assign ack = r_q.ack;
  assign rdata = r_q.rdata;
  assign addr = r_q.addr;
  assign area0_select_n = !area_hit(active, r_q.area, 3'h0);
  generate
    for (genvar i = 0; i < 5; i++) begin : g_sel
      assign area_selects_n[i] = !area_hit(active, r_q.area, 3'(i + 2));
    end
  endgenerate
  assign bus_cycle_start_n = !(r_q.st == nmb_pkg::NMB_START);
  assign read_n = !(strobe && !r_q.write);
  assign read_write = !(active && r_q.write);
  assign lane0_write_select_n = strobe ? we_n[0] : 1'b1;
  assign lane1_write_select_n = strobe ? we_n[1] : 1'b1;
  assign lane2_write_select_n = we_n[2];
  assign lane3_write_select_n = we_n[3];
  // pins of the other memory kinds stay parked in this mode;
  // the card 16-bit indicator has no effect on a normal-memory cycle
  assign upper_row_strobe_n = 1'b1;
  assign lower_row_strobe_n = 1'b1;
  assign upper_column_strobe_n = 1'b1;
  assign lower_column_strobe_n = 1'b1;
  assign card_a_second_enable_n = 1'b1;
  assign card_b_second_enable_n = 1'b1;
  assign sdram_clock_enable = 1'b0; // indicator input deliberately unread

  // write data lanes: beat byte on lane 0 for 8-bit, halfword otherwise
  // an odd byte on a 16-bit bus moves up to lane 1; lanes are only
  // enabled during writes, so reads never fight the far side
  always_comb begin
    data_out = 32'h0000_0000;
    if (eff_width == nmb_pkg::WIDTH_8) begin
      data_out[7:0] = r_q.wdata[8*r_q.beat +: 8];
    end else begin
      data_out[15:0] = r_q.addr[0] && r_q.size == nmb_pkg::SIZE_BYTE ?
        {r_q.wdata[7:0], 8'h00} : r_q.wdata[15:0];
    end
    data_oe = 32'h0000_0000;
    if (active && r_q.write) begin
      data_oe[7:0] = {8{lane_oe[0]}};
      data_oe[15:8] = {8{lane_oe[1]}};
    end
  end
endmodule // nmb_bus

// ===== test/nmb_bus_asserts.sv
// checker for the normal-memory bus pins of nmb_bus
// assumes it is bound to nmb_bus, one clock, synchronous reset
`timescale 1ns/10ps
module nmb_bus_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic read_n,
  input wire logic read_write,
  input wire logic bus_cycle_start_n,
  input wire logic area0_select_n,
  input wire logic [4:0] area_selects_n,
  input wire logic lane0_write_select_n,
  input wire logic lane1_write_select_n,
  input wire logic lane2_write_select_n,
  input wire logic lane3_write_select_n,
  input wire logic upper_row_strobe_n,
  input wire logic lower_row_strobe_n,
  input wire logic upper_column_strobe_n,
  input wire logic lower_column_strobe_n,
  input wire logic card_a_second_enable_n,
  input wire logic card_b_second_enable_n,
  input wire logic sdram_clock_enable,
  input wire logic wait_n,
  input wire logic [31:0] data_oe
);
  logic strobe;
  // ====
  // strobe phase of reads and writes
  assign strobe = !read_n || !lane0_write_select_n || !lane1_write_select_n;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_sel; !bus_cycle_start_n && !(area0_select_n && &area_selects_n); endsequence
  sequence s_gap; bus_cycle_start_n [*2]; endsequence
  property p_start; !bus_cycle_start_n |-> s_sel ##1 s_gap; endproperty
  a_start: assert property (p_start) else $error("start without select");
  property p_rd_lanes; !read_n |-> lane0_write_select_n && lane1_write_select_n; endproperty
  a_rd_lanes: assert property (p_rd_lanes) else $error("write select low in read");
  property p_rd_dir; $fell(read_n) |-> read_write && !$past(bus_cycle_start_n); endproperty
  a_rd_dir: assert property (p_rd_dir) else $error("read strobe order or direction");
  property p_wr; !(lane0_write_select_n && lane1_write_select_n) |-> !read_write && read_n; endproperty
  a_wr: assert property (p_wr) else $error("write direction or read strobe");
  property p_upper_we; lane2_write_select_n && lane3_write_select_n; endproperty
  a_upper_we: assert property (p_upper_we) else $error("upper write select low");
  property p_upper_data; data_oe[31:16] == 16'h0000; endproperty
  a_upper_data: assert property (p_upper_data) else $error("upper data driven");
  property p_quiet;
    upper_row_strobe_n && lower_row_strobe_n && upper_column_strobe_n && lower_column_strobe_n
      && card_a_second_enable_n && card_b_second_enable_n && !sdram_clock_enable;
  endproperty
  a_quiet: assert property (p_quiet) else $error("sdram or card pin active");
  property p_wait; strobe && !wait_n |=> strobe; endproperty
  a_wait: assert property (p_wait) else $error("wait not honoured");
endmodule // nmb_bus_asserts

// ===== test/nmb_mem_model.sv
// static memory model on the far side of the normal-memory bus
// assumes addresses below 256 and write selects active low
`timescale 1ns/10ps
module nmb_mem_model (
  input wire logic clock,
  input wire logic bus16,
  input wire logic [3:0] wait_cyc,
  input wire logic [25:0] addr,
  input wire logic read_n,
  input wire logic sel0_n,
  input wire logic sel1_n,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata,
  output logic wait_n
);
  logic [7:0] mem [256];
  logic [3:0] cnt_q = 4'h0;
  logic [7:0] pat_q = 8'h5a;
  logic strobe;
  logic [7:0] a;
  // ====
  // wait stretch for the first wait_cyc strobe cycles
  assign strobe = !read_n || !sel0_n || !sel1_n;
  assign a = addr[7:0];
  assign wait_n = !(strobe && cnt_q < wait_cyc);
  // byte lane writes; pattern toggles so released lanes never hold
  always_ff @(posedge clock) begin
    pat_q <= ~pat_q;
    cnt_q <= strobe ? cnt_q + 4'h1 : 4'h0;
    if (!sel0_n) mem[a] <= wdata[7:0];
    if (!sel1_n) mem[a | 8'h01] <= wdata[15:8];
  end
  // read lanes, little endian
  always_comb begin
    rdata = {4{pat_q}};
    if (!read_n) begin
      rdata[7:0] = bus16 ? mem[a & 8'hfe] : mem[a];
      if (bus16) rdata[15:8] = mem[a | 8'h01];
    end
  end
endmodule // nmb_mem_model

// ===== test/nmb_bus_tb.sv
// bench for nmb_bus with a static memory model
// assumes area 0 strapped to 8-bit, other areas asked at 16-bit
`timescale 1ns/10ps
module nmb_bus_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic wr = 1'b0;
  logic [1:0] sz = 2'h0;
  logic [2:0] ar = 3'h2;
  logic [25:0] ad = 26'h000_0000;
  logic [31:0] wd = 32'h0000_0000;
  logic [5:0] st = 6'h2d;
  logic bus16 = 1'b1;
  logic [3:0] wait_cyc = 4'h0;
  logic ack, read_n, rw, bcs_n, a0_n, l0_n, l1_n, big_endian, wait_n;
  logic [2:0] clock_mode;
  logic [4:0] asel_n;
  logic [25:0] addr, a_first, a_last;
  logic [31:0] rdata, data_in, data_out, data_oe;
  logic [1:0] wmask, oemask;
  logic [5:0] smask;
  int err_total = 0;
  int total_checks = 0;
  int n, beats;
  always #25 clock = ~clock;
  nmb_bus dut (.clock(clock), .rst(rst), .clock_mode_strap_0(st[0]), .clock_mode_strap_1(st[1]),
    .clock_mode_strap_2(st[2]), .area0_width_strap_0(st[3]), .area0_width_strap_1(st[4]),
    .endian_strap(st[5]), .req(req), .req_write(wr), .req_size(sz), .req_area(ar), .req_width(2'h2),
    .req_addr(ad), .req_wdata(wd), .ack(ack), .rdata(rdata), .clock_mode(clock_mode),
    .big_endian(big_endian), .addr(addr), .area0_select_n(a0_n), .area_selects_n(asel_n),
    .bus_cycle_start_n(bcs_n), .read_n(read_n), .read_write(rw), .lane0_write_select_n(l0_n),
    .lane1_write_select_n(l1_n), .lane2_write_select_n(), .lane3_write_select_n(), .upper_row_strobe_n(),
    .lower_row_strobe_n(), .upper_column_strobe_n(), .lower_column_strobe_n(), .card_a_second_enable_n(),
    .card_b_second_enable_n(), .sdram_clock_enable(), .card_io_16bit_indicator(~bus16), .wait_n(wait_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  nmb_mem_model u_mem (.clock(clock), .bus16(bus16), .wait_cyc(wait_cyc), .addr(addr), .read_n(read_n),
    .sel0_n(l0_n), .sel1_n(l1_n), .wdata(data_out), .rdata(data_in), .wait_n(wait_n));
  // ====
  // compare and closing report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one access, watching the pins each cycle until ack
  task automatic acc(input logic w, input logic [1:0] s, input logic [2:0] r, input logic [25:0] a,
                     input logic [31:0] d);
    @(negedge clock);
    {req, wr, sz, ar, ad, wd} = {1'b1, w, s, r, a, d};
    n = 0;
    beats = 0;
    {wmask, oemask, smask} = 10'h000;
    do begin
      @(negedge clock);
      n++;
      req = 1'b0;
      if (!bcs_n) begin
        beats++;
        a_last = addr;
        smask |= ~{asel_n, a0_n};
        if (beats == 1) a_first = addr;
      end
      if (!read_n || !l0_n || !l1_n) begin
        wmask |= ~{l1_n, l0_n};
        oemask |= {|data_oe[15:8], |data_oe[7:0]};
      end
    end while (!ack && n < 200);
    chk("ack", 32'h0000_0001, 32'(ack));
    chk("select", r == 3'h0 ? 32'h0000_0001 : 32'h0000_0001 << (r - 3'h1), 32'(smask));
    if (!ack) end_sim();
  endtask
  // ====
  // scenarios
  task automatic t_straps;
    chk("clock_mode", 32'h0000_0005, 32'(clock_mode));
    chk("big_endian", 32'h0000_0001, 32'(big_endian));
    $display("test straps done");
  endtask
  task automatic t_bus16;
    logic [1:0] szs [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
    logic [1:0] msk [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
    logic [25:0] adr [4] = '{26'h000_0010, 26'h000_0011, 26'h000_0012, 26'h000_0014};
    logic [31:0] dat [4] = '{32'ha1a1_a1a1, 32'hb2b2_b2b2, 32'hd4c3_d4c3, 32'h8765_4321};
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, szs[i], 3'(i + 2), adr[i], dat[i]);
      chk("write lanes", 32'(msk[i]), 32'(wmask));
      chk("driven lanes 16", 32'(msk[i]), 32'(oemask));
      chk("first address", 32'(adr[i]), 32'(a_first));
    end
    wait_cyc = 4'h2;
    acc(1'b0, 2'h1, 3'h6, 26'h000_0010, 32'h0000_0000);
    chk("read data 16", 32'h0000_b2a1, 32'(rdata[15:0]));
    chk("read cycles", 32'h0000_0006, 32'(n));
    chk("read lanes", 32'h0000_0000, 32'(wmask));
    wait_cyc = 4'h0;
    $display("test bus16 done");
  endtask
  task automatic t_bus8;
    bus16 = 1'b0;
    acc(1'b1, 2'h2, 3'h0, 26'h000_0020, 32'h4433_2211);
    chk("beats", 32'h0000_0004, 32'(beats));
    chk("last address", 32'h0000_0023, 32'(a_last));
    chk("write lanes", 32'h0000_0001, 32'(wmask));
    chk("driven lanes", 32'h0000_0001, 32'(oemask));
    chk("cycles", 32'h0000_000d, 32'(n));
    acc(1'b1, 2'h1, 3'h0, 26'h000_0030, 32'h0000_6655);
    chk("last address", 32'h0000_0031, 32'(a_last));
    acc(1'b0, 2'h2, 3'h0, 26'h000_0020, 32'h0000_0000);
    chk("read data 8", 32'h4433_2211, rdata);
    $display("test bus8 done");
  endtask
  // ====
  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    t_straps();
    t_bus16();
    t_bus8();
    end_sim();
  end
endmodule // nmb_bus_tb
bind nmb_bus nmb_bus_asserts u_chk (.clock(clock), .rst(rst), .read_n(read_n), .read_write(read_write),
  .bus_cycle_start_n(bus_cycle_start_n), .area0_select_n(area0_select_n), .area_selects_n(area_selects_n),
  .lane0_write_select_n(lane0_write_select_n), .lane1_write_select_n(lane1_write_select_n),
  .lane2_write_select_n(lane2_write_select_n), .lane3_write_select_n(lane3_write_select_n),
  .upper_row_strobe_n(upper_row_strobe_n), .lower_row_strobe_n(lower_row_strobe_n),
  .upper_column_strobe_n(upper_column_strobe_n), .lower_column_strobe_n(lower_column_strobe_n),
  .card_a_second_enable_n(card_a_second_enable_n), .card_b_second_enable_n(card_b_second_enable_n),
  .sdram_clock_enable(sdram_clock_enable), .wait_n(wait_n), .data_oe(data_oe));
